// *** vstf_regs.sv ***
// stream framing configuration registers behind a classic wishbone slave
// assumes a 32-bit wishbone master on clk_sys and a framing engine that
// pulses line_start at the start of each video line
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module vstf_regs
    import vstf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic line_start,
    output logic framing_go,
    output logic [6:0] tu_size,
    output logic stream_interlaced,
    output logic [7:0] unit_min_bytes,
    output logic [9:0] unit_fraction_bytes,
    output logic [6:0] line_start_delay,
    output logic [15:0] horizontal_total,
    output logic [15:0] vertical_total,
    output logic vsync_polarity,
    output logic hsync_polarity
);

    // =========================================================
    // bus decode
    wire bus_req = wb_cyc_i && wb_stb_i;
    logic ack_ff;
    wire wr_now = bus_req && wb_we_i && ack_ff;
    wire [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire hit_tu = (wb_adr_i == VSTF_OFS_TU_SIZE);
    wire hit_intl = (wb_adr_i == VSTF_OFS_INTERLACE);
    wire hit_min = (wb_adr_i == VSTF_OFS_MIN_BYTES);
    wire hit_frac = (wb_adr_i == VSTF_OFS_FRAC_BYTES);
    wire hit_wait = (wb_adr_i == VSTF_OFS_LINE_DELAY);
    wire hit_ht = (wb_adr_i == VSTF_OFS_HTOTAL);
    wire hit_vt = (wb_adr_i == VSTF_OFS_VTOTAL);
    wire hit_pol = (wb_adr_i == VSTF_OFS_POLARITY);
    wire hit_stat = (wb_adr_i == VSTF_OFS_STATUS);

    // =========================================================
    // registers
    logic [6:0] tu_ff;
    logic intl_ff;
    logic [7:0] min_ff;
    logic [9:0] frac_ff;
    logic [6:0] wait_ff;
    logic [15:0] ht_ff;
    logic [15:0] vt_ff;
    logic [1:0] pol_ff;
    logic [31:0] rdat_ff;

    // merged write words, only the sel lanes change
    wire [31:0] m_tu = ({25'h0, tu_ff} & ~byte_mask) | (wb_dat_i & byte_mask);
    wire [31:0] m_intl = ({31'h0, intl_ff} & ~byte_mask)
        | (wb_dat_i & byte_mask);
    wire [31:0] m_min = ({24'h0, min_ff} & ~byte_mask) | (wb_dat_i & byte_mask);
    wire [31:0] m_frac = ({22'h0, frac_ff} & ~byte_mask)
        | (wb_dat_i & byte_mask);
    wire [31:0] m_wait = ({25'h0, wait_ff} & ~byte_mask)
        | (wb_dat_i & byte_mask);
    wire [31:0] m_ht = ({16'h0, ht_ff} & ~byte_mask) | (wb_dat_i & byte_mask);
    wire [31:0] m_vt = ({16'h0, vt_ff} & ~byte_mask) | (wb_dat_i & byte_mask);
    wire [31:0] m_pol = ({30'h0, pol_ff} & ~byte_mask)
        | (wb_dat_i & byte_mask);

    // lsb of unit size is written as zero and resets to zero, so it stays even
    wire [6:0] nxt_tu = (wr_now && hit_tu) ? {m_tu[6:1], 1'b0} : tu_ff;
    wire nxt_intl = (wr_now && hit_intl) ? m_intl[VSTF_INTERLACE_BIT] : intl_ff;
    wire [7:0] nxt_min = (wr_now && hit_min) ? m_min[7:0] : min_ff;
    wire [9:0] nxt_frac = (wr_now && hit_frac) ? m_frac[9:0] : frac_ff;
    wire [6:0] nxt_wait = (wr_now && hit_wait) ? m_wait[6:0] : wait_ff;
    wire [15:0] nxt_ht = (wr_now && hit_ht) ? m_ht[15:0] : ht_ff;
    wire [15:0] nxt_vt = (wr_now && hit_vt) ? m_vt[15:0] : vt_ff;
    wire [1:0] nxt_pol = (wr_now && hit_pol) ? m_pol[1:0] : pol_ff;
    wire nxt_ack = bus_req && !ack_ff;

    // =========================================================
    // line timer
    vstf_wait_if wif ();
    logic go_ff;

    assign wif.line_start = line_start;
    assign wif.wait_cycles = wait_ff;

    vstf_line_wait u_line_wait (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wif(wif)
    );

    // =========================================================
    // read mux, unmapped and reserved bits read zero
    wire [31:0] nxt_rdat = hit_tu ? {25'h0, tu_ff} :
        hit_intl ? {31'h0, intl_ff} :
        hit_min ? {24'h0, min_ff} :
        hit_frac ? {22'h0, frac_ff} :
        hit_wait ? {25'h0, wait_ff} :
        hit_ht ? {16'h0, ht_ff} :
        hit_vt ? {16'h0, vt_ff} :
        hit_pol ? {30'h0, pol_ff} :
        hit_stat ? {31'h0, wif.busy} : 32'h0000_0000;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
            go_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_ack ? nxt_rdat : 32'h0000_0000;
            go_ff <= wif.go;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tu_ff <= VSTF_RST_TU_SIZE;
            intl_ff <= 1'b0;
            min_ff <= VSTF_RST_MIN;
            frac_ff <= VSTF_RST_FRAC;
            wait_ff <= VSTF_RST_WAIT;
            ht_ff <= VSTF_RST_TOTAL;
            vt_ff <= VSTF_RST_TOTAL;
            pol_ff <= VSTF_RST_POL;
        end
        else
        begin
            tu_ff <= nxt_tu;
            intl_ff <= nxt_intl;
            min_ff <= nxt_min;
            frac_ff <= nxt_frac;
            wait_ff <= nxt_wait;
            ht_ff <= nxt_ht;
            vt_ff <= nxt_vt;
            pol_ff <= nxt_pol;
        end
    end

    // =========================================================
    // outputs, all straight from flip-flops
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign framing_go = go_ff;
    assign tu_size = tu_ff;
    assign stream_interlaced = intl_ff;
    assign unit_min_bytes = min_ff;
    assign unit_fraction_bytes = frac_ff;
    assign line_start_delay = wait_ff;
    assign horizontal_total = ht_ff;
    assign vertical_total = vt_ff;
    assign vsync_polarity = pol_ff[VSTF_POL_VSYNC_BIT];
    assign hsync_polarity = pol_ff[VSTF_POL_HSYNC_BIT];

    // =========================================================
    // checks
    ack_one_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after request");
    ht_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_now && hit_ht && wb_sel_i == 4'hF
        |=> horizontal_total == $past(wb_dat_i[15:0]))
        else $error("horizontal total not taken from write");
    vt_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_now && hit_vt && wb_sel_i == 4'hF
        |=> vertical_total == $past(wb_dat_i[15:0]))
        else $error("vertical total not taken from write");
    pol_bits_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_now && hit_pol && wb_sel_i[0]
        |=> vsync_polarity == $past(wb_dat_i[1])
        && hsync_polarity == $past(wb_dat_i[0]))
        else $error("sync polarity bits swapped or lost");
    intl_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_now && hit_intl && wb_sel_i[0]
        |=> stream_interlaced == $past(wb_dat_i[0]))
        else $error("interlace flag not updated by write");
    tu_even_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tu_size[0] == 1'b0)
        else $error("transfer unit size became odd");
    readback_ht_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_req && !wb_we_i && hit_ht && !wb_ack_o
        |=> wb_dat_o == {16'h0, horizontal_total})
        else $error("read back differs from stored value");
    rd_idle_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");

endmodule
`default_nettype wire

// *** vstf_pkg.sv ***
// register map and reset values of the stream framing register bank
// assumes a 32-bit classic wishbone slave port with byte addresses
package vstf_pkg;

    // =========================================================
    // register byte offsets
    localparam logic [11:0] VSTF_OFS_TU_SIZE = 12'h530;
    localparam logic [11:0] VSTF_OFS_INTERLACE = 12'h540;
    localparam logic [11:0] VSTF_OFS_MIN_BYTES = 12'h544;
    localparam logic [11:0] VSTF_OFS_FRAC_BYTES = 12'h548;
    localparam logic [11:0] VSTF_OFS_LINE_DELAY = 12'h54C;
    localparam logic [11:0] VSTF_OFS_HTOTAL = 12'h550;
    localparam logic [11:0] VSTF_OFS_VTOTAL = 12'h554;
    localparam logic [11:0] VSTF_OFS_POLARITY = 12'h558;
    localparam logic [11:0] VSTF_OFS_STATUS = 12'h5F0;

    // =========================================================
    // field widths and positions
    localparam int VSTF_TU_W = 7;
    localparam int VSTF_MIN_W = 8;
    localparam int VSTF_FRAC_W = 10;
    localparam int VSTF_WAIT_W = 7;
    localparam int VSTF_TOTAL_W = 16;
    localparam int VSTF_POL_W = 2;
    localparam int VSTF_POL_VSYNC_BIT = 1;
    localparam int VSTF_POL_HSYNC_BIT = 0;
    localparam int VSTF_INTERLACE_BIT = 0;
    localparam int VSTF_STAT_BUSY_BIT = 0;

    // =========================================================
    // reset values
    localparam logic [6:0] VSTF_RST_TU_SIZE = 7'h40;
    localparam logic [6:0] VSTF_RST_TU_MIN = 7'h20;
    localparam logic [6:0] VSTF_RST_WAIT = 7'h00;
    localparam logic [7:0] VSTF_RST_MIN = 8'h00;
    localparam logic [9:0] VSTF_RST_FRAC = 10'h000;
    localparam logic [15:0] VSTF_RST_TOTAL = 16'h0000;
    localparam logic [1:0] VSTF_RST_POL = 2'h0;

    // =========================================================
    // wait timer states
    typedef enum logic [0:0] {
        VSTF_IDLE = 1'b0,
        VSTF_COUNT = 1'b1
    } vstf_state_t;

endpackage

// *** vstf_wait_if.sv ***
// carries the line start request and the wait count to the line timer
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface vstf_wait_if;
    logic line_start;
    logic [6:0] wait_cycles;
    logic go;
    logic busy;

    modport ctrl (output line_start, output wait_cycles, input go,
        input busy);
    modport timer (input line_start, input wait_cycles, output go,
        output busy);
endinterface
`default_nettype wire

// *** vstf_line_wait.sv ***
// line start timer: holds off framing for a programmed number of cycles
// assumes line_start is a one-cycle pulse from the same clock domain
`timescale 1ns/100ps
`default_nettype none
module vstf_line_wait
    import vstf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    vstf_wait_if.timer wif
);

    // =========================================================
    // state
    vstf_state_t state_ff;
    vstf_state_t nxt_state;
    logic [6:0] cnt_ff;
    logic [6:0] nxt_cnt;
    logic go_ff;
    logic nxt_go;

    wire cnt_done = (cnt_ff == 7'h00);

    // a fresh line start restarts the wait, even mid-count
    assign nxt_state = wif.line_start ? VSTF_COUNT :
        ((state_ff == VSTF_COUNT) && cnt_done) ? VSTF_IDLE : state_ff;
    assign nxt_cnt = wif.line_start ? wif.wait_cycles :
        ((state_ff == VSTF_COUNT) && !cnt_done) ? cnt_ff - 7'h01 : cnt_ff;
    assign nxt_go = !wif.line_start && (state_ff == VSTF_COUNT) && cnt_done;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= VSTF_IDLE;
            cnt_ff <= VSTF_RST_WAIT;
            go_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            go_ff <= nxt_go;
        end
    end

    assign wif.go = go_ff;
    assign wif.busy = (state_ff == VSTF_COUNT);

    // =========================================================
    // checks
    // go follows n+1 counting edges, so a wait of five shows go on the 7th
    wait_five_go_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wif.line_start && wif.wait_cycles == 7'h05 ##1 (!wif.line_start)[*6]
        |=> wif.go)
        else $error("framing go not given after wait of five");
    wait_no_early_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wif.line_start && wif.wait_cycles == 7'h05 |=> (!wif.go)[*6])
        else $error("framing go given before wait ended");

endmodule
`default_nettype wire

// *** vstf_regs_tb.sv ***
// self-checking bench for the stream framing register bank
// assumes vstf_regs as the only design top, driven over classic wishbone
`timescale 1ns/100ps
`default_nettype none
module vstf_regs_tb
    import vstf_pkg::*;
;
    // =========================================================
    // clock, reset and stimulus
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, line_start = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, framing_go, stream_interlaced, vsync_pol, hsync_pol;
    logic [6:0] tu_size, line_start_delay;
    logic [7:0] unit_min_bytes;
    logic [9:0] unit_fraction_bytes;
    logic [15:0] horizontal_total, vertical_total;
    int n_errors = 0;
    int compares = 0;
    int scaled, wpl, lane_cnt;
    localparam int ACTIVE_PIXELS_PER_LINE = 1920;
    localparam int BITS_PER_PIXEL = 24;
    localparam int LINK_BANDWIDTH = 500;
    localparam int VIDEO_BANDWIDTH = 750;
    logic [11:0] ofs [8] = '{VSTF_OFS_TU_SIZE, VSTF_OFS_INTERLACE,
        VSTF_OFS_MIN_BYTES, VSTF_OFS_FRAC_BYTES, VSTF_OFS_LINE_DELAY,
        VSTF_OFS_HTOTAL, VSTF_OFS_VTOTAL, VSTF_OFS_POLARITY};
    logic [31:0] msk [8] = '{32'h7E, 32'h1, 32'hFF, 32'h3FF, 32'h7F,
        32'hFFFF, 32'hFFFF, 32'h3};

    always #10 clk_sys = ~clk_sys;

    vstf_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .line_start(line_start), .framing_go(framing_go),
        .tu_size(tu_size), .stream_interlaced(stream_interlaced),
        .unit_min_bytes(unit_min_bytes),
        .unit_fraction_bytes(unit_fraction_bytes),
        .line_start_delay(line_start_delay),
        .horizontal_total(horizontal_total),
        .vertical_total(vertical_total), .vsync_polarity(vsync_pol),
        .hsync_polarity(hsync_pol));

    // =========================================================
    // reporting
    task automatic end_of_test();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // =========================================================
    // wishbone single cycle; waits for ack, never assumes latency
    task automatic wb(input logic w, input logic [11:0] a,
        input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        i = 0;
        do
        begin
            @(posedge clk_sys);
            i++;
        end
        while (wb_ack_o !== 1'b1 && i < 20);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (i >= 20)
        begin
            chk("ack timeout", 32'h1, 32'h0);
            end_of_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, 4'hF, d, q);
        // the write lands on the ack edge; let it pass before ports are read
        @(posedge clk_sys);
    endtask

    // pulse line_start; count edges until the go pulse, then check width
    task automatic line_go(input int n_exp);
        int k;
        @(posedge clk_sys);
        line_start <= 1'b1;
        @(posedge clk_sys);
        line_start <= 1'b0;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (framing_go !== 1'b1 && k < 300);
        chk("go delay", k, n_exp);
        @(posedge clk_sys);
        chk("go width", {31'h0, framing_go}, 32'h0);
    endtask

    // =========================================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk("tu_size port", {25'h0, tu_size}, 32'h40);
        for (int r = 0; r < 8; r++)
        begin
            wb(1'b0, ofs[r], 4'hF, 32'h0, rd);
            chk("reset value", rd, (r == 0) ? 32'h40 : 32'h0);
        end
        $display("test reset values done");

        for (int r = 0; r < 8; r++)
        begin
            wr(ofs[r], 32'hFFFF_FFFF);
            wb(1'b0, ofs[r], 4'hF, 32'h0, rd);
            chk("all ones readback", rd, msk[r]);
        end
        chk("tu port", {25'h0, tu_size}, 32'h7E);
        chk("min port", {24'h0, unit_min_bytes}, 32'hFF);
        chk("frac port", {22'h0, unit_fraction_bytes}, 32'h3FF);
        chk("htotal port", {16'h0, horizontal_total}, 32'hFFFF);
        chk("vtotal port", {16'h0, vertical_total}, 32'hFFFF);
        chk("interlace port", {31'h0, stream_interlaced}, 32'h1);
        $display("test readback done");

        wb(1'b1, VSTF_OFS_HTOTAL, 4'h1, 32'h0000_0012, rd);
        wb(1'b0, VSTF_OFS_HTOTAL, 4'hF, 32'h0, rd);
        chk("byte lane write", rd, 32'hFF12);
        wr(VSTF_OFS_TU_SIZE, 32'h33);
        wb(1'b0, VSTF_OFS_TU_SIZE, 4'hF, 32'h0, rd);
        chk("tu odd write", rd, 32'h32);
        wr(VSTF_OFS_POLARITY, 32'h2);
        chk("pol v1 h0", {30'h0, vsync_pol, hsync_pol}, 32'h2);
        wr(VSTF_OFS_POLARITY, 32'h1);
        chk("pol v0 h1", {30'h0, vsync_pol, hsync_pol}, 32'h1);
        wr(VSTF_OFS_INTERLACE, 32'h0);
        chk("interlace off", {31'h0, stream_interlaced}, 32'h0);
        wr(VSTF_OFS_VTOTAL, 32'h0000_0465);
        chk("vtotal value", {16'h0, vertical_total}, 32'h465);
        wr(12'h5A0, 32'hFFFF_FFFF);
        wb(1'b0, 12'h5A0, 4'hF, 32'h0, rd);
        chk("unmapped read", rd, 32'h0);
        $display("test fields done");

        wr(VSTF_OFS_LINE_DELAY, 32'h0);
        line_go(3);
        wr(VSTF_OFS_LINE_DELAY, 32'h5);
        line_go(8);
        wr(VSTF_OFS_LINE_DELAY, 32'h7F);
        line_go(130);
        // a second line start must cancel the first count
        wr(VSTF_OFS_LINE_DELAY, 32'hA);
        @(posedge clk_sys);
        line_start <= 1'b1;
        @(posedge clk_sys);
        line_start <= 1'b0;
        repeat (3) @(posedge clk_sys);
        line_go(13);
        wr(VSTF_OFS_LINE_DELAY, 32'h14);
        @(posedge clk_sys);
        line_start <= 1'b1;
        @(posedge clk_sys);
        line_start <= 1'b0;
        wb(1'b0, VSTF_OFS_STATUS, 4'hF, 32'h0, rd);
        chk("busy while waiting", rd, 32'h1);
        repeat (30) @(posedge clk_sys);
        wb(1'b0, VSTF_OFS_STATUS, 4'hF, 32'h0, rd);
        chk("idle after go", rd, 32'h0);
        $display("test line timer done");

        // software setup: rgb stream, unit size 64, four lanes
        wpl = (ACTIVE_PIXELS_PER_LINE * BITS_PER_PIXEL + 15) / 16;
        lane_cnt = (wpl % 4 == 0) ? wpl - 4 : wpl + wpl % 4 - 4;
        scaled = LINK_BANDWIDTH * 64 * 1000 / VIDEO_BANDWIDTH;
        wr(VSTF_OFS_MIN_BYTES, scaled / 1000);
        wr(VSTF_OFS_FRAC_BYTES, scaled % 1000);
        wr(VSTF_OFS_INTERLACE, 32'h1);
        chk("min bytes", {24'h0, unit_min_bytes}, 32'h2A);
        chk("frac bytes", {22'h0, unit_fraction_bytes}, 32'h29A);
        chk("interlaced", {31'h0, stream_interlaced}, 32'h1);
        wr(VSTF_OFS_LINE_DELAY, 64 - scaled / 1000);
        chk("delay port", {25'h0, line_start_delay}, 32'h16);
        line_go(25);
        wr(VSTF_OFS_LINE_DELAY, (64 - scaled / 1000) / 2);
        line_go(14);
        wr(VSTF_OFS_LINE_DELAY, (64 - scaled / 1000) / 3);
        line_go(10);
        // small units always wait 64
        wr(VSTF_OFS_LINE_DELAY, 32'h40);
        line_go(67);
        $display("test setup done, lane count %0d", lane_cnt);
        end_of_test();
    end
endmodule
`default_nettype wire
